/* logic/rsr_remote_status.sv */
// Status bytes, masks, lamps and command pacing
`timescale 1ns/100ps
module rsr_remote_status
   import rsr_pkg::*;
#(
   parameter int unsigned LAMP_CYCLES_P = LAMP_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire rsr_cmd_s cmd_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_data_o,
   input wire logic cmd_enqueued_i,
   input wire logic queue_empty_i,
   input wire logic char_activity_i,
   input wire logic cmd_error_i,
   input wire logic exec_error_i,
   input wire logic out_overflow_i,
   input wire logic meas_busy_i,
   input wire logic meas_ready_i,
   input wire logic [5:0] inst_event_i,
   input wire logic settings_invalid_i,
   input wire logic key_press_event_i,
   input wire logic remote_i,
   output logic [7:0] serial_poll_o,
   output logic activity_lamp_o,
   output logic error_lamp_o,
   output logic remote_lamp_o,
   output logic keys_locked_o,
   output logic setup_reset_o
);
   // ***********************
   // Declarations
   // ***********************
   logic [7:0] ese_mask;
   logic [7:0] sre_mask;
   logic [7:0] ism_mask;
   logic [7:0] evt;
   logic [7:0] ist;
   logic [7:0] next_evt;
   logic [7:0] next_ist;
   logic [7:0] sp_core;
   logic [7:0] slot_ese [SLOTS];
   logic [7:0] slot_sre [SLOTS];
   logic [7:0] slot_ism [SLOTS];
   logic opc_armed;
   logic no_cmd;
   logic first;
   logic key_s1;
   logic key_s2;
   logic key_q;
   logic key_edge;
   logic take;
   logic slot_ok;
   logic exe_err;
   logic opc_done;
   logic clr;
   logic [1:0] lamp;
   logic [1:0] trig;
   logic [3:0] slot;

   function automatic logic [7:0] pick(input logic [7:0] b, input rsr_cmd_s c);
      pick = c.has_bit ? {7'h00, b[c.bit_idx]} : b;
   endfunction : pick

   assign take = ce_i & cmd_valid_i & cmd_ready_o;
   assign slot_ok = cmd_i.arg < 8'(SLOTS);
   assign slot = cmd_i.arg[3:0];
   assign clr = take & (cmd_i.op == OP_CLS || cmd_i.op == OP_RST);
   assign opc_done = opc_armed & ~meas_busy_i;
   assign exe_err = exec_error_i | (take & ~slot_ok & (cmd_i.op == OP_SAV || cmd_i.op == OP_RCL));
   assign key_edge = key_s2 & ~key_q & ~remote_lamp_o;
   assign activity_lamp_o = lamp[0];
   assign error_lamp_o = lamp[1];
   assign trig[0] = char_activity_i;
   assign trig[1] = cmd_error_i | exe_err | out_overflow_i;

   // ***********************
   // Pin synchroniser
   // ***********************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         key_s1 <= 1'b0;
         key_s2 <= 1'b0;
         key_q <= 1'b0;
      end else if (ce_i) begin
         key_s1 <= key_press_event_i;
         key_s2 <= key_s1;
         key_q <= key_s2;
      end
   end

   // ***********************
   // Command pacing
   // ***********************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_ready_o <= 1'b1;
      end else if (ce_i) begin
         if (take && cmd_i.op == OP_WAI && meas_busy_i) begin
            cmd_ready_o <= 1'b0;
         end else if (!meas_busy_i) begin
            cmd_ready_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         opc_armed <= 1'b0;
      end else if (ce_i) begin
         if (take && cmd_i.op == OP_OPC) begin
            opc_armed <= 1'b1;
         end else if (opc_done) begin
            opc_armed <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         no_cmd <= 1'b1;
      end else if (ce_i) begin
         if (cmd_enqueued_i) begin
            no_cmd <= 1'b0;
         end else if (queue_empty_i) begin
            no_cmd <= 1'b1;
         end
      end
   end

   // ***********************
   // Event and instrument status bytes
   // ***********************
   always_comb begin
      next_evt = clr ? 8'h00 : evt;
      next_evt[EV_OPC] = next_evt[EV_OPC] | opc_done;
      next_evt[EV_QRY] = next_evt[EV_QRY] | out_overflow_i;
      next_evt[EV_EXE] = next_evt[EV_EXE] | exe_err;
      next_evt[EV_CMD] = next_evt[EV_CMD] | cmd_error_i;
      next_evt[EV_KEY] = next_evt[EV_KEY] | key_edge;
      next_ist = clr ? IST_RST : ist;
      next_ist[IS_MEAS_W-1:0] = next_ist[IS_MEAS_W-1:0] | inst_event_i;
      next_ist[IS_MEM] = next_ist[IS_MEM] | (first & settings_invalid_i);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         evt <= EVT_RST;
         ist <= IST_RST;
         first <= 1'b1;
      end else if (ce_i) begin
         evt <= next_evt;
         ist <= next_ist;
         first <= 1'b0;
      end
   end

   // ***********************
   // Enable masks and setup slots
   // ***********************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ese_mask <= MASK_RST;
         sre_mask <= MASK_RST;
         ism_mask <= MASK_RST;
      end else if (take) begin
         case (cmd_i.op)
            OP_ESE_SET: ese_mask <= cmd_i.arg;
            OP_SRE_SET: sre_mask <= cmd_i.arg;
            OP_ISM_SET: ism_mask <= cmd_i.arg;
            OP_RST: begin
               ese_mask <= MASK_RST;
               sre_mask <= MASK_RST;
               ism_mask <= MASK_RST;
            end
            OP_RCL: begin
               if (slot_ok) begin
                  ese_mask <= slot_ese[slot];
                  sre_mask <= slot_sre[slot];
                  ism_mask <= slot_ism[slot];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (take && cmd_i.op == OP_SAV && slot_ok) begin
         slot_ese[slot] <= ese_mask;
         slot_sre[slot] <= sre_mask;
         slot_ism[slot] <= ism_mask;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         setup_reset_o <= 1'b0;
      end else if (ce_i) begin
         setup_reset_o <= take & (cmd_i.op == OP_RST);
      end
   end

   // ***********************
   // Serial poll byte
   // ***********************
   always_comb begin
      sp_core = 8'h00;
      sp_core[SP_READY] = meas_ready_i;
      sp_core[SP_INST] = |(ist & ism_mask);
      sp_core[SP_EVT] = |(evt & ese_mask);
      sp_core[SP_NOCMD] = no_cmd;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         serial_poll_o <= 8'h00;
      end else if (ce_i) begin
         serial_poll_o <= sp_core;
         serial_poll_o[SP_SRQ] <= |(sp_core & sre_mask);
      end
   end

   // ***********************
   // Query responses
   // ***********************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o <= 8'h00;
      end else if (ce_i) begin
         rsp_valid_o <= 1'b1;
         case (take ? cmd_i.op : OP_NOP)
            OP_ESE_Q: rsp_data_o <= pick(ese_mask, cmd_i);
            OP_ESR_Q: rsp_data_o <= pick(evt, cmd_i);
            OP_SRE_Q: rsp_data_o <= pick(sre_mask, cmd_i);
            OP_STB_Q: rsp_data_o <= pick(serial_poll_o & 8'hbf, cmd_i);
            OP_ISM_Q: rsp_data_o <= pick(ism_mask, cmd_i);
            OP_IST_Q: rsp_data_o <= pick(ist, cmd_i);
            default: rsp_valid_o <= 1'b0;
         endcase
      end
   end

   // ***********************
   // Lamps
   // ***********************
   generate
      for (genvar i = 0; i < 2; i++) begin : g_lamp
         logic [19:0] cnt;
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               cnt <= 20'h00000;
               lamp[i] <= 1'b0;
            end else if (ce_i) begin
               if (trig[i]) begin
                  cnt <= 20'(LAMP_CYCLES_P - 1);
                  lamp[i] <= 1'b1;
               end else if (cnt != 20'h00000) begin
                  cnt <= cnt - 20'h00001;
               end else begin
                  lamp[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         remote_lamp_o <= 1'b0;
         keys_locked_o <= 1'b0;
      end else if (ce_i) begin
         remote_lamp_o <= remote_i;
         keys_locked_o <= remote_i;
      end
   end

   // ***********************
   // Checks
   // ***********************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_opc;
      ce_i && opc_armed && !meas_busy_i |=> evt[EV_OPC];
   endproperty
   a_opc: assert property (p_opc) else $error("opc bit not set");

   property p_wai;
      take && cmd_i.op == OP_WAI && meas_busy_i |=> !cmd_ready_o;
   endproperty
   a_wai: assert property (p_wai) else $error("wait did not stall");

   property p_ese;
      take && cmd_i.op == OP_ESE_SET |=> ese_mask == $past(cmd_i.arg);
   endproperty
   a_ese: assert property (p_ese) else $error("event mask not written");

   property p_bitq;
      take && cmd_i.has_bit && cmd_i.op == OP_ESR_Q |=> rsp_valid_o && rsp_data_o[7:1] == 7'h00;
   endproperty
   a_bitq: assert property (p_bitq) else $error("bit query too wide");

   property p_nocmd;
      ce_i && cmd_enqueued_i |=> !no_cmd ##1 (!ce_i || !serial_poll_o[SP_NOCMD]);
   endproperty
   a_nocmd: assert property (p_nocmd) else $error("no-command not cleared");

   property p_stb;
      take && cmd_i.op == OP_STB_Q |=> !rsp_data_o[SP_NOCMD];
   endproperty
   a_stb: assert property (p_stb) else $error("status query shows no-command");

   property p_unused;
      serial_poll_o[2:1] == 2'b00 && !serial_poll_o[7] && !evt[1] && !evt[3];
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");

   property p_power_on;
      $fell(reset_i) |-> evt[7];
   endproperty
   a_power_on: assert property (p_power_on) else $error("power-on bit missing");

   property p_cls;
      take && cmd_i.op == OP_CLS |=> ese_mask == $past(ese_mask) && sre_mask == $past(sre_mask);
   endproperty
   a_cls: assert property (p_cls) else $error("clear altered mask");

   property p_errlamp;
      ce_i && cmd_error_i |=> error_lamp_o && evt[EV_CMD];
   endproperty
   a_errlamp: assert property (p_errlamp) else $error("error not shown");
endmodule : rsr_remote_status

/* logic/rsr_pkg.sv */
// Constants and types of the remote status reporting block
package rsr_pkg;
   // ***********************
   // Timing
   // ***********************
   localparam int CLK_NS = 100;
   localparam int LAMP_US = 50000;
   localparam int LAMP_CYCLES = LAMP_US * 1000 / CLK_NS;
   // ***********************
   // Layout and reset values
   // ***********************
   localparam int SLOTS = 10;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] EVT_RST = 8'h80;
   localparam logic [7:0] IST_RST = 8'h00;
   localparam int SP_READY = 0;
   localparam int SP_INST = 3;
   localparam int SP_EVT = 4;
   localparam int SP_SRQ = 5;
   localparam int SP_NOCMD = 6;
   localparam int EV_OPC = 0;
   localparam int EV_QRY = 2;
   localparam int EV_EXE = 4;
   localparam int EV_CMD = 5;
   localparam int EV_KEY = 6;
   localparam int IS_MEM = 7;
   localparam int IS_MEAS_W = 6;
   // ***********************
   // Types
   // ***********************
   typedef enum logic [3:0] {
      OP_NOP, OP_OPC, OP_WAI, OP_RST, OP_SAV, OP_RCL, OP_CLS,
      OP_ESE_SET, OP_ESE_Q, OP_ESR_Q, OP_SRE_SET, OP_SRE_Q,
      OP_STB_Q, OP_ISM_SET, OP_ISM_Q, OP_IST_Q
   } rsr_op_e;
   typedef struct packed {
      rsr_op_e op;
      logic [7:0] arg;
      logic has_bit;
      logic [2:0] bit_idx;
   } rsr_cmd_s;
endpackage : rsr_pkg

/* tb/rsr_host_model.sv */
// Host model that offers decoded commands and collects answers
`timescale 1ns/100ps
module rsr_host_model
   import rsr_pkg::*;
(
   input wire logic clk_i,
   input wire logic cmd_ready_i,
   input wire logic rsp_valid_i,
   input wire logic [7:0] rsp_data_i,
   output rsr_cmd_s cmd_o,
   output logic cmd_valid_o
);
   initial begin
      cmd_o = '0;
      cmd_valid_o = 1'b0;
   end
   // Hold the command until taken, then read any answer
   task automatic xfer(input rsr_op_e o, input logic [7:0] a, input logic hb, input logic [2:0] ix,
      input logic q, output logic [7:0] d, output logic ok);
      logic r;
      int n;
      d = 8'h00;
      n = 0;
      @(posedge clk_i);
      cmd_o <= '{o, a, hb, ix};
      cmd_valid_o <= 1'b1;
      do begin
         @(negedge clk_i);
         r = cmd_ready_i;
         n++;
         @(posedge clk_i);
      end while (r !== 1'b1 && n < 200);
      cmd_valid_o <= 1'b0;
      cmd_o <= '{OP_NOP, ~a, ~hb, ~ix};
      ok = (r === 1'b1);
      if (q) begin
         @(negedge clk_i);
         d = rsp_data_i;
         ok = ok && (rsp_valid_i === 1'b1);
      end
   endtask : xfer
endmodule : rsr_host_model

/* tb/tb.sv */
// Self-checking bench of the remote status block
`timescale 1ns/100ps
module tb;
   import rsr_pkg::*;
   localparam int LP = 4;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [5:0] ev = '0;
   logic busy = 1'b0;
   logic qe = 1'b1;
   logic remote = 1'b0;
   logic ce = 1'b1;
   logic mrdy = 1'b1;
   logic sinv = 1'b0;
   logic [5:0] ie = '0;
   rsr_cmd_s cmd;
   logic cv, crdy, rv, al, el, rl, kl, sr;
   logic [7:0] rd, sp, d;
   logic ok;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   int k;
   rsr_op_e st[3] = '{OP_ESE_SET, OP_SRE_SET, OP_ISM_SET};
   rsr_op_e qr[3] = '{OP_ESE_Q, OP_SRE_Q, OP_ISM_Q};
   always #50 clk_i = ~clk_i;
   rsr_remote_status #(.LAMP_CYCLES_P(LP)) u_rsr_remote_status (.clk_i(clk_i), .reset_i(reset_i),
      .ce_i(ce), .cmd_i(cmd), .cmd_valid_i(cv), .cmd_ready_o(crdy), .rsp_valid_o(rv),
      .rsp_data_o(rd), .cmd_enqueued_i(ev[0]), .queue_empty_i(qe), .char_activity_i(ev[1]),
      .cmd_error_i(ev[2]), .exec_error_i(ev[3]), .out_overflow_i(ev[4]), .meas_busy_i(busy),
      .meas_ready_i(mrdy), .inst_event_i(ie), .settings_invalid_i(sinv), .key_press_event_i(ev[5]),
      .remote_i(remote), .serial_poll_o(sp), .activity_lamp_o(al), .error_lamp_o(el),
      .remote_lamp_o(rl), .keys_locked_o(kl), .setup_reset_o(sr));
   rsr_host_model u_rsr_host_model (.clk_i(clk_i), .cmd_ready_i(crdy), .rsp_valid_i(rv),
      .rsp_data_i(rd), .cmd_o(cmd), .cmd_valid_o(cv));
   // ***********************
   // Tasks
   // ***********************
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic run(input rsr_op_e o, input logic [7:0] a);
      u_rsr_host_model.xfer(o, a, 1'b0, 3'h0, 1'b0, d, ok);
   endtask : run
   task automatic qry(input rsr_op_e o, input logic hb, input logic [2:0] i, input logic [7:0] e);
      u_rsr_host_model.xfer(o, 8'h00, hb, i, 1'b1, d, ok);
      chk("answer valid", 8'h01, {7'h0, ok});
      chk(o.name(), e, d);
   endtask : qry
   task automatic pulse(input int i, input int n);
      @(posedge clk_i);
      ev[i] <= 1'b1;
      tick(n);
      ev[i] <= 1'b0;
   endtask : pulse
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         $display("ERROR timeout expected 0 got 1");
         tally_and_finish();
      end
   end
   // ***********************
   // Tests
   // ***********************
   initial begin
      tick(2);
      reset_i <= 1'b0;
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h80);
      qry(OP_STB_Q, 1'b0, 3'h0, 8'h01);
      qry(OP_STB_Q, 1'b1, 3'h0, 8'h01);
      qry(OP_ESR_Q, 1'b1, 3'h7, 8'h01);
      for (int i = 0; i < 3; i++) begin
         run(st[i], 8'hff);
         qry(qr[i], 1'b0, 3'h0, 8'hff);
         run(st[i], 8'h00);
         qry(qr[i], 1'b0, 3'h0, 8'h00);
      end
      $display("test reset_and_masks done");
      for (int i = 1; i < 5; i++) begin
         pulse(i, 1);
         tick(1);
         @(negedge clk_i);
         chk("lamp on", 8'h01, {7'h0, (i == 1) ? al : el});
         tick(LP + 4);
         @(negedge clk_i);
         chk("lamp off", 8'h00, {7'h0, (i == 1) ? al : el});
      end
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'hb4);
      run(OP_ESE_SET, 8'h40);
      run(OP_CLS, 8'h00);
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h00);
      qry(OP_ESE_Q, 1'b0, 3'h0, 8'h40);
      $display("test errors done");
      tick(1);
      remote <= 1'b1;
      tick(2);
      @(negedge clk_i);
      chk("remote lamps", 8'h03, {6'h0, rl, kl});
      pulse(5, 3);
      tick(4);
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h00);
      tick(1);
      remote <= 1'b0;
      pulse(5, 3);
      tick(4);
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h40);
      @(negedge clk_i);
      chk("poll", 8'h51, sp);
      run(OP_SRE_SET, 8'h10);
      tick(3);
      @(negedge clk_i);
      chk("poll", 8'h71, sp);
      tick(1);
      ie <= 6'h01;
      tick(1);
      ie <= 6'h00;
      run(OP_ISM_SET, 8'h01);
      tick(3);
      @(negedge clk_i);
      chk("poll inst", 8'h08, sp & 8'h08);
      qry(OP_IST_Q, 1'b1, 3'h0, 8'h01);
      qry(OP_IST_Q, 1'b0, 3'h0, 8'h01);
      $display("test summaries done");
      tick(1);
      qe <= 1'b0;
      pulse(0, 1);
      tick(2);
      @(negedge clk_i);
      chk("no command", 8'h00, sp & 8'h40);
      tick(1);
      qe <= 1'b1;
      tick(3);
      @(negedge clk_i);
      chk("no command", 8'h40, sp & 8'h40);
      tick(1);
      busy <= 1'b1;
      run(OP_OPC, 8'h00);
      tick(3);
      qry(OP_ESR_Q, 1'b1, 3'h0, 8'h00);
      run(OP_WAI, 8'h00);
      tick(4);
      @(negedge clk_i);
      chk("ready while busy", 8'h00, {7'h0, crdy});
      tick(1);
      busy <= 1'b0;
      tick(3);
      @(negedge clk_i);
      chk("ready after busy", 8'h01, {7'h0, crdy});
      qry(OP_ESR_Q, 1'b1, 3'h0, 8'h01);
      $display("test pacing done");
      run(OP_ESE_SET, 8'h21);
      run(OP_SAV, 8'h02);
      run(OP_ESE_SET, 8'h00);
      run(OP_RCL, 8'h02);
      qry(OP_ESE_Q, 1'b0, 3'h0, 8'h21);
      run(OP_SAV, 8'h0a);
      tick(3);
      qry(OP_ESR_Q, 1'b1, 3'h4, 8'h01);
      run(OP_RST, 8'h00);
      k = 0;
      repeat (3) begin
         @(negedge clk_i);
         k += (sr === 1'b1);
      end
      chk("reset pulses", 8'h01, k[7:0]);
      qry(OP_ESE_Q, 1'b0, 3'h0, 8'h00);
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h00);
      $display("test setup done");
      tick(1);
      ce <= 1'b0;
      pulse(2, 1);
      tick(2);
      @(negedge clk_i);
      chk("frozen lamp", 8'h00, {7'h0, el});
      tick(1);
      ce <= 1'b1;
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h00);
      tick(1);
      mrdy <= 1'b0;
      tick(3);
      @(negedge clk_i);
      chk("poll ready", 8'h00, sp & 8'h01);
      tick(1);
      sinv <= 1'b1;
      reset_i <= 1'b1;
      tick(2);
      reset_i <= 1'b0;
      mrdy <= 1'b1;
      tick(1);
      sinv <= 1'b0;
      qry(OP_IST_Q, 1'b0, 3'h0, 8'h80);
      qry(OP_ESR_Q, 1'b0, 3'h0, 8'h80);
      $display("test freeze and reset done");
      tally_and_finish();
   end
endmodule : tb
